// ### rtl/crc_ladder_tap.sv
/*
 * Ladder tap fraction: numerator over 96 of the selected source.
 * Assumes range and tap come from registered control bits.
 */
`timescale 1ns/1ps
module crc_ladder_tap
	import crc_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Control
	input  wire logic       range_i,
	input  wire logic [3:0] tap_i,
	// Result
	output logic [6:0]      fraction_o
);

	typedef struct packed {
		logic [6:0] frac;
	} crc_tap_st_t;

	crc_tap_st_t s_q;
	crc_tap_st_t s_d;

	// 96 is the common base of the 1/24 and 1/32 steps
	function automatic logic [6:0] tap_frac(input logic rng, input logic [3:0] tap);
		logic [6:0] t;
		t = {3'h0, tap};
		if (rng) begin
			tap_frac = 7'(t * CRC_ZERO_STEP);
		end else begin
			tap_frac = 7'(CRC_OFS_BASE + t * CRC_OFS_STEP);
		end
	endfunction

	always_comb begin
		s_d      = s_q;
		s_d.frac = tap_frac(range_i, tap_i);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign fraction_o = s_q.frac;

endmodule

// ### rtl/crc_pkg.sv
/*
 * Shared constants and types for the comparator reference control block.
 * Assumes a 32-bit classic Wishbone master and analog logic that takes
 * static control levels.
 */
package crc_pkg;

	// Bus geometry
	localparam int CRC_DW = 32;
	localparam int CRC_AW = 8;

	// Register byte offsets
	localparam logic [CRC_AW-1:0] CRC_CTRL_OFS = 8'h00;
	localparam logic [CRC_AW-1:0] CRC_STAT_OFS = 8'h04;

	// Control register reset value and writable bits
	localparam logic [15:0] CRC_CTRL_RST   = 16'h0000;
	localparam logic [15:0] CRC_CTRL_WMASK = 16'h47FF;

	// Control register field positions
	localparam int CRC_HALF_OE_BIT = 14;
	localparam int CRC_NONINV_BIT  = 10;
	localparam int CRC_BG_LSB      = 8;
	localparam int CRC_PWR_BIT     = 7;
	localparam int CRC_PIN_OE_BIT  = 6;
	localparam int CRC_RANGE_BIT   = 5;
	localparam int CRC_SRC_BIT     = 4;
	localparam int CRC_TAP_LSB     = 0;

	// Status register field positions
	localparam int CRC_ST_PIN_BIT  = 0;
	localparam int CRC_ST_HALF_BIT = 1;
	localparam int CRC_ST_PWR_BIT  = 2;
	localparam int CRC_ST_FRAC_LSB = 8;

	// Ladder fraction expressed in 96ths of the source
	localparam logic [6:0] CRC_FRAC_DEN  = 7'h60;
	localparam logic [6:0] CRC_ZERO_STEP = 7'h04;
	localparam logic [6:0] CRC_OFS_STEP  = 7'h03;
	localparam logic [6:0] CRC_OFS_BASE  = 7'h18;

	typedef enum logic [1:0] {
		CRC_BG_1V2   = 2'h0,
		CRC_BG_0V6   = 2'h1,
		CRC_BG_0V2   = 2'h2,
		CRC_BG_VREFP = 2'h3
	} crc_bg_t;

	typedef enum logic [1:0] {
		CRC_IDLE = 2'h1,
		CRC_ACK  = 2'h2
	} crc_bus_st_t;

	typedef struct packed {
		logic        unused15;
		logic        half_reference_output_enable;
		logic [2:0]  unused13;
		logic        noninverting_reference_select;
		crc_bg_t     bandgap_level_select;
		logic        reference_ladder_power_enable;
		logic        reference_pin_output_enable;
		logic        ladder_range_select;
		logic        ladder_source_select;
		logic [3:0]  ladder_tap_value;
	} crc_ctrl_t;

	typedef struct packed {
		logic              cyc;
		logic              stb;
		logic              we;
		logic [CRC_AW-1:0] adr;
		logic [3:0]        sel;
		logic [CRC_DW-1:0] dat;
	} crc_wb_req_t;

	typedef struct packed {
		logic              ack;
		logic [CRC_DW-1:0] dat;
	} crc_wb_rsp_t;

	typedef struct packed {
		logic       ladder_power_enable;
		logic       ladder_source_select;
		logic       ladder_range_select;
		logic [3:0] ladder_tap_value;
		logic       noninverting_reference_select;
		logic [1:0] bandgap_level_select;
		logic [3:0] bandgap_onehot;
		logic       reference_pin_drive;
		logic       pin_digital_oe;
		logic       half_reference_drive;
	} crc_analog_t;

	typedef struct packed {
		crc_bus_st_t st;
		crc_wb_rsp_t rsp;
		crc_ctrl_t   ctrl;
		crc_analog_t ana;
	} crc_state_t;

endpackage

// ### rtl/crc_top.sv
/*
 * Comparator reference control register with a Wishbone slave.
 * Assumes a classic Wishbone master on clk_i and analog logic that
 * consumes the registered control levels below.
 */
`timescale 1ns/1ps

// Overview of operation
// - Bits 15 and 13..11 read zero, ignore writes
// - Bit 14 connects half reference to pin
// - Bit 10 picks non-inverting reference source
// - Bits 9..8 pick inverting band-gap level
// - Bit 7 powers reference ladder on
// - Bit 6 routes reference to shared pin
// - Reference output enable overrides pin direction
// - Bit 5 picks 1/24 or 1/32 range
// - Bit 4 picks external or supply source
// - Bits 3..0 choose ladder tap
module crc_top
	import crc_pkg::*;
(
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// Wishbone slave
	input  wire crc_wb_req_t  wb_req_i,
	output crc_wb_rsp_t       wb_rsp_o,
	// Pin direction of the shared reference pin, high means input
	input  wire logic         pin_direction_control_i,
	// Analog control
	output crc_analog_t       analog_o,
	output logic [6:0]        ladder_fraction_o
);

	crc_state_t s_q;
	crc_state_t s_d;

	logic        bus_hit;
	logic        ctrl_sel;
	logic        wr_commit;
	logic [15:0] wr_data;
	logic [6:0]  frac;

	assign bus_hit   = wb_req_i.cyc & wb_req_i.stb;
	assign ctrl_sel  = (wb_req_i.adr == CRC_CTRL_OFS);
	assign wr_data   = wb_req_i.dat[15:0];
	// Write lands on the edge where the master samples ack
	assign wr_commit = (s_q.st == CRC_ACK) & bus_hit & wb_req_i.we & ctrl_sel;

	// Byte-lane merge; unimplemented bits never stored
	function automatic crc_ctrl_t ctrl_merge(
		input crc_ctrl_t  old,
		input logic [15:0] dat,
		input logic [3:0]  sel
	);
		logic [15:0] lane;
		logic [15:0] m;
		lane = {{8{sel[1]}}, {8{sel[0]}}};
		m    = lane & CRC_CTRL_WMASK;
		ctrl_merge = crc_ctrl_t'((old & ~m) | (dat & m));
	endfunction

	function automatic logic [CRC_DW-1:0] status_word(
		input crc_analog_t a,
		input logic [6:0]  f
	);
		logic [CRC_DW-1:0] w;
		w = '0;
		w[CRC_ST_PIN_BIT]  = a.reference_pin_drive;
		w[CRC_ST_HALF_BIT] = a.half_reference_drive;
		w[CRC_ST_PWR_BIT]  = a.ladder_power_enable;
		w[CRC_ST_FRAC_LSB +: 7] = f;
		status_word = w;
	endfunction

	function automatic logic [CRC_DW-1:0] read_word(
		input logic [CRC_AW-1:0] adr,
		input crc_ctrl_t         c,
		input crc_analog_t       a,
		input logic [6:0]        f
	);
		logic [CRC_DW-1:0] w;
		w = '0;
		case (adr)
			CRC_CTRL_OFS: begin
				w[15:0] = 16'(c) & CRC_CTRL_WMASK;
			end
			CRC_STAT_OFS: begin
				w = status_word(a, f);
			end
			default: begin
				w = '0;
			end
		endcase
		read_word = w;
	endfunction

	// Analog levels are decoded from the next control value
	function automatic crc_analog_t analog_decode(
		input crc_ctrl_t c,
		input logic      dir_in
	);
		crc_analog_t a;
		a = '0;
		a.ladder_power_enable           = c.reference_ladder_power_enable;
		a.ladder_source_select          = c.ladder_source_select;
		a.ladder_range_select           = c.ladder_range_select;
		a.ladder_tap_value              = c.ladder_tap_value;
		a.noninverting_reference_select = c.noninverting_reference_select;
		a.bandgap_level_select          = c.bandgap_level_select;
		a.bandgap_onehot                = 4'h1 << c.bandgap_level_select;
		a.reference_pin_drive           = c.reference_pin_output_enable;
		// Analog path wins; digital driver kept off to avoid contention
		a.pin_digital_oe = ~c.reference_pin_output_enable & ~dir_in;
		a.half_reference_drive = c.half_reference_output_enable;
		analog_decode = a;
	endfunction

	crc_ladder_tap u_tap (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.range_i    (s_q.ctrl.ladder_range_select),
		.tap_i      (s_q.ctrl.ladder_tap_value),
		.fraction_o (frac)
	);

	always_comb begin
		s_d         = s_q;
		s_d.rsp.ack = 1'b0;
		case (s_q.st)
			CRC_IDLE: begin
				if (bus_hit) begin
					s_d.st      = CRC_ACK;
					s_d.rsp.ack = 1'b1;
					s_d.rsp.dat = read_word(wb_req_i.adr, s_q.ctrl, s_q.ana, frac);
				end
			end
			CRC_ACK: begin
				s_d.st = CRC_IDLE;
				if (wr_commit) begin
					s_d.ctrl = ctrl_merge(s_q.ctrl, wr_data, wb_req_i.sel);
				end
			end
			default: begin
				s_d.st = CRC_IDLE;
			end
		endcase
		s_d.ana = analog_decode(s_d.ctrl, pin_direction_control_i);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q.st   <= CRC_IDLE;
			s_q.rsp  <= '0;
			s_q.ctrl <= crc_ctrl_t'(CRC_CTRL_RST);
			s_q.ana  <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign wb_rsp_o          = s_q.rsp;
	assign analog_o          = s_q.ana;
	assign ladder_fraction_o = frac;

	// Checks

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	logic [6:0] exp_frac;
	assign exp_frac = s_q.ctrl.ladder_range_select ?
		7'({3'h0, s_q.ctrl.ladder_tap_value} * CRC_ZERO_STEP) :
		7'(CRC_OFS_BASE + {3'h0, s_q.ctrl.ladder_tap_value} * CRC_OFS_STEP);

	a_unimpl_read_zero: assert property (
		(s_q.st == CRC_IDLE) && bus_hit && !wb_req_i.we && ctrl_sel
		|=> wb_rsp_o.ack && wb_rsp_o.dat[15] == 1'b0 && wb_rsp_o.dat[13:11] == 3'h0
	) else $error("unimplemented control bits read nonzero");

	a_unimpl_store_zero: assert property (
		wr_commit && wb_req_i.sel[1]
		|=> s_q.ctrl.unused15 == 1'b0 && s_q.ctrl.unused13 == 3'h0
	) else $error("unimplemented control bits were stored");

	a_half_oe_follow: assert property (
		wr_commit && wb_req_i.sel[1]
		|=> analog_o.half_reference_drive == $past(wr_data[CRC_HALF_OE_BIT])
	) else $error("half reference drive does not follow write");

	a_noninv_sel_follow: assert property (
		wr_commit && wb_req_i.sel[1]
		|=> analog_o.noninverting_reference_select == $past(wr_data[CRC_NONINV_BIT])
	) else $error("non-inverting select does not follow write");

	a_bandgap_onehot: assert property (
		(!rst_i && $stable(s_q.ctrl.bandgap_level_select))[*2]
		|-> analog_o.bandgap_onehot == (4'h1 << analog_o.bandgap_level_select)
		&& analog_o.bandgap_level_select == s_q.ctrl.bandgap_level_select
	) else $error("band-gap decode mismatch");

	a_power_follow: assert property (
		wr_commit && wb_req_i.sel[0]
		|=> analog_o.ladder_power_enable == $past(wr_data[CRC_PWR_BIT])
	) else $error("ladder power does not follow write");

	a_pin_route: assert property (
		wr_commit && wb_req_i.sel[0]
		|=> analog_o.reference_pin_drive == $past(wr_data[CRC_PIN_OE_BIT])
	) else $error("reference pin route does not follow write");

	a_pin_override: assert property (
		analog_o.reference_pin_drive |-> !analog_o.pin_digital_oe
	) else $error("digital driver active while reference drives pin");

	a_range_follow: assert property (
		wr_commit && wb_req_i.sel[0]
		|=> analog_o.ladder_range_select == $past(wr_data[CRC_RANGE_BIT])
	) else $error("range select does not follow write");

	a_source_follow: assert property (
		wr_commit && wb_req_i.sel[0]
		|=> analog_o.ladder_source_select == $past(wr_data[CRC_SRC_BIT])
	) else $error("source select does not follow write");

	a_tap_fraction: assert property (
		!rst_i && $stable(s_q.ctrl) |=> ladder_fraction_o == $past(exp_frac)
	) else $error("ladder fraction wrong for tap and range");

	a_reset_clear: assert property (
		$past(rst_i) |-> s_q.ctrl == crc_ctrl_t'(CRC_CTRL_RST) && analog_o == '0
	) else $error("control not cleared after reset");

	a_ack_single: assert property (
		wb_rsp_o.ack |=> !wb_rsp_o.ack
	) else $error("ack held longer than one cycle");

	a_ack_latency: assert property (
		(s_q.st == CRC_IDLE) && bus_hit
		|=> wb_rsp_o.ack
	) else $error("ack missing one cycle after request");

	a_ack_needs_req: assert property (
		wb_rsp_o.ack
		|-> $past(bus_hit) && s_q.st == CRC_ACK
	) else $error("ack without a request");

	a_state_onehot: assert property (
		$onehot(s_q.st)
	) else $error("bus state not one-hot");

	a_reset_idle: assert property (
		$past(rst_i)
		|-> !wb_rsp_o.ack && s_q.st == CRC_IDLE && ladder_fraction_o == 7'h00
	) else $error("bus side not idle after reset");

	a_rsp_upper_zero: assert property (
		wb_rsp_o.dat[31:16] == 16'h0000
	) else $error("read data upper half nonzero");

	a_ctrl_readback: assert property (
		(s_q.st == CRC_IDLE) && bus_hit && !wb_req_i.we && ctrl_sel
		|=> wb_rsp_o.dat[15:0] == $past(16'(s_q.ctrl))
	) else $error("control read data differs from stored value");

	a_stat_readback: assert property (
		(s_q.st == CRC_IDLE) && bus_hit && !wb_req_i.we
		&& wb_req_i.adr == CRC_STAT_OFS
		|=> wb_rsp_o.dat[CRC_ST_PWR_BIT] == $past(analog_o.ladder_power_enable)
		&& wb_rsp_o.dat[CRC_ST_HALF_BIT] == $past(analog_o.half_reference_drive)
		&& wb_rsp_o.dat[CRC_ST_PIN_BIT] == $past(analog_o.reference_pin_drive)
		&& wb_rsp_o.dat[CRC_ST_FRAC_LSB +: 7] == $past(ladder_fraction_o)
	) else $error("status read data wrong");

	a_unmapped_read: assert property (
		(s_q.st == CRC_IDLE) && bus_hit && !wb_req_i.we
		&& !ctrl_sel && wb_req_i.adr != CRC_STAT_OFS
		|=> wb_rsp_o.dat == '0
	) else $error("unmapped read returned nonzero");

	a_other_write_ignored: assert property (
		!rst_i && !wr_commit
		|=> $stable(s_q.ctrl)
	) else $error("control changed without a write");

	a_low_lane_keep: assert property (
		wr_commit && !wb_req_i.sel[0]
		|=> s_q.ctrl[7:0] == $past(s_q.ctrl[7:0])
	) else $error("low control byte written without its lane");

	a_high_lane_keep: assert property (
		wr_commit && !wb_req_i.sel[1]
		|=> s_q.ctrl[15:8] == $past(s_q.ctrl[15:8])
	) else $error("high control byte written without its lane");

	a_tap_follow: assert property (
		wr_commit && wb_req_i.sel[0]
		|=> analog_o.ladder_tap_value == $past(wr_data[CRC_TAP_LSB +: 4])
	) else $error("ladder tap does not follow write");

	a_bandgap_follow: assert property (
		wr_commit && wb_req_i.sel[1]
		|=> analog_o.bandgap_level_select == $past(wr_data[CRC_BG_LSB +: 2])
	) else $error("band-gap select does not follow write");

	a_power_match: assert property (
		analog_o.ladder_power_enable == s_q.ctrl.reference_ladder_power_enable
	) else $error("ladder power differs from control");

	a_source_match: assert property (
		analog_o.ladder_source_select == s_q.ctrl.ladder_source_select
	) else $error("source select differs from control");

	a_range_match: assert property (
		analog_o.ladder_range_select == s_q.ctrl.ladder_range_select
	) else $error("range select differs from control");

	a_noninv_match: assert property (
		analog_o.noninverting_reference_select == s_q.ctrl.noninverting_reference_select
	) else $error("non-inverting select differs from control");

	a_half_match: assert property (
		analog_o.half_reference_drive == s_q.ctrl.half_reference_output_enable
	) else $error("half reference drive differs from control");

	a_pin_match: assert property (
		analog_o.reference_pin_drive == s_q.ctrl.reference_pin_output_enable
	) else $error("reference pin route differs from control");

	a_tap_match: assert property (
		analog_o.ladder_tap_value == s_q.ctrl.ladder_tap_value
	) else $error("ladder tap differs from control");

	a_pin_dir_oe: assert property (
		!rst_i
		|=> analog_o.pin_digital_oe
			== (!analog_o.reference_pin_drive && !$past(pin_direction_control_i))
	) else $error("digital pin enable wrong for direction");

	a_fraction_bound: assert property (
		ladder_fraction_o < CRC_FRAC_DEN
	) else $error("ladder fraction beyond full scale");

	a_offset_floor: assert property (
		!rst_i && !s_q.ctrl.ladder_range_select
		|=> ladder_fraction_o >= CRC_OFS_BASE
	) else $error("offset range fraction below one quarter");

endmodule

// ### sim/tb.sv
/*
 * Self-checking bench for the comparator reference control register.
 * Assumes crc_top with its registered Wishbone slave and analog outputs.
 */
`timescale 1ns/1ps
module tb
	import crc_pkg::*;
;
	logic        clk_i;
	logic        rst_i;
	logic        pin_dir;
	logic        dir_n;
	crc_wb_req_t req;
	crc_wb_rsp_t rsp;
	crc_analog_t ana;
	logic [6:0]  frac;
	logic [31:0] seed;
	logic [31:0] rd;
	logic [31:0] r;
	logic [15:0] ctrl_e;
	int          n_mismatch;
	int          n_checks;
	logic [15:0] corner [8] = '{16'hFFFF, 16'h0000, 16'h002F, 16'h000F,
		16'h0120, 16'h0210, 16'h03C0, 16'h4400};

	crc_top dut_u (
		.clk_i                   (clk_i),
		.rst_i                   (rst_i),
		.wb_req_i                (req),
		.wb_rsp_o                (rsp),
		.pin_direction_control_i (pin_dir),
		.analog_o                (ana),
		.ladder_fraction_o       (frac)
	);

	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic crc_analog_t exp_ana(input logic [15:0] c, input logic dir);
		return '{c[7], c[4], c[5], c[3:0], c[10], c[9:8], 4'h1 << c[9:8], c[6],
			!c[6] && !dir, c[14]};
	endfunction

	function automatic logic [6:0] exp_frac(input logic [15:0] c);
		return c[5] ? 7'(c[3:0]) * 7'h04 : 7'h18 + 7'(c[3:0]) * 7'h03;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk_ana(input crc_analog_t got, input crc_analog_t exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Waits for ack as long as needed; only the watchdog ends a silent slave
	task automatic bus(input logic we, input logic [7:0] a, input logic [15:0] d,
		input logic [3:0] s);
		@(posedge clk_i);
		req <= '{1'b1, 1'b1, we, a, s, {16'h0000, d}};
		pin_dir <= dir_n;
		do begin
			@(posedge clk_i);
		end while (rsp.ack !== 1'b1);
		rd = rsp.dat;
		req <= '0;
		repeat (2) @(posedge clk_i);
		#1;
	endtask

	task automatic verify();
		bus(1'b0, CRC_CTRL_OFS, 16'h0000, 4'hF);
		chk(rd, {16'h0000, ctrl_e});
		chk_ana(ana, exp_ana(ctrl_e, pin_dir));
		bus(1'b0, CRC_STAT_OFS, 16'h0000, 4'hF);
		chk(rd, {17'h0, exp_frac(ctrl_e), 5'h0, ctrl_e[7], ctrl_e[14], ctrl_e[6]});
		chk({25'h0, frac}, {25'h0, exp_frac(ctrl_e)});
	endtask

	task automatic wr(input logic [15:0] d, input logic [3:0] s);
		logic [15:0] m;
		m = {{8{s[1]}}, {8{s[0]}}} & CRC_CTRL_WMASK;
		bus(1'b1, CRC_CTRL_OFS, d, s);
		ctrl_e = (ctrl_e & ~m) | (d & m);
		verify();
	endtask

	task automatic stop_test();
		if (n_mismatch == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk_i);
		n_mismatch++;
		stop_test();
	end

	initial begin
		seed = 32'h1A;
		rst_i = 1'b1;
		req = '0;
		pin_dir = 1'b0;
		dir_n = 1'b0;
		ctrl_e = 16'h0000;
		n_mismatch = 0;
		n_checks = 0;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		verify();
		// Corners first, then random data and lane enables; pin direction random on every write
		for (int i = 0; i < 40; i++) begin
			r = rnd();
			dir_n = r[20];
			if (i < 8)
				wr(corner[i], 4'hF);
			else
				wr(r[15:0], r[19:16]);
		end
		wr(16'hFFFF, 4'hF);
		bus(1'b0, 8'h08, 16'h0000, 4'hF);
		chk(rd, 32'h0000_0000);
		bus(1'b1, CRC_STAT_OFS, 16'h0000, 4'hF);
		bus(1'b1, 8'hFC, 16'h0000, 4'hF);
		verify();
		// Reset in mid-run must clear everything written so far
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		ctrl_e = 16'h0000;
		verify();
		stop_test();
	end
endmodule
